// *** inc/sci_pkg.sv ***
// constants and types shared by the serial transmitter, receiver and rate divider
package sci_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_CTRL1 = 8'h08;
  localparam logic [7:0] OFF_CTRL2 = 8'h0C;
  localparam logic [7:0] OFF_RATE = 8'h10;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int ST_HE = 7;
  localparam int ST_FD = 6;
  localparam int ST_RF = 5;
  localparam int ST_FF = 1;
  localparam int C1_RX9 = 7;
  localparam int C1_TX9 = 6;
  localparam int C1_LEN9 = 4;
  localparam int C2_HEIE = 7;
  localparam int C2_FDIE = 6;
  localparam int C2_RFIE = 5;
  localparam int C2_SENDON = 3;
  localparam int C2_RECVON = 2;
  localparam int C2_BRK = 0;
  localparam int RT_PRE = 6;
  localparam int RT_SEND = 3;
  localparam int RT_RECV = 0;
  // ------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [3:0] PHASE_LAST = 4'hF;
  localparam logic [3:0] START_MID = 4'h7;
  localparam logic [3:0] LEN_WORD8 = 4'hA;
  localparam logic [3:0] LEN_WORD9 = 4'hB;
  localparam logic [3:0] LEN_MARK = 4'h1;
  localparam logic [10:0] PRE_F1 = 11'h001;
  localparam logic [10:0] PRE_F3 = 11'h003;
  localparam logic [10:0] PRE_F4 = 11'h004;
  localparam logic [10:0] PRE_F13 = 11'h00D;
  typedef enum logic [1:0] {K_DATA = 2'b00, K_IDLE = 2'b01, K_BREAK = 2'b10,
    K_MARK = 2'b11} kind_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01,
    RX_DATA = 2'b10} rxst_t;
endpackage

// *** src/rate_gen.sv ***
// rate divider giving a one-cycle enable at sixteen times the bit rate
`timescale 1ns/1ps
module rate_gen (
  // clock and reset
  input wire logic clk,
  input wire logic rstN,
  // configuration
  input wire logic run,
  input wire logic [1:0] preCode,
  input wire logic [2:0] divCode,
  // enable out
  output logic tick
);
  logic [10:0] pre;
  logic [10:0] factor;
  logic [10:0] cnt_q;

  always_comb
  begin
    case (preCode)
      2'b00: pre = sci_pkg::PRE_F1;
      2'b01: pre = sci_pkg::PRE_F3;
      2'b10: pre = sci_pkg::PRE_F4;
      default: pre = sci_pkg::PRE_F13;
    endcase
  end
  assign factor = pre << divCode;

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      cnt_q <= 11'h000;
      tick <= 1'b0;
    end
    else if (!run)
    begin
      cnt_q <= 11'h000;
      tick <= 1'b0;
    end
    else if (cnt_q == factor - 11'h001)
    begin
      cnt_q <= 11'h000;
      tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 11'h001;
      tick <= 1'b0;
    end
  end

  property p_pre13;
    @(posedge clk) disable iff (!rstN)
    run && preCode == 2'b11 && divCode == 3'b000 && tick |=> (run -> !tick) [*8];
  endproperty
  a_pre13: assert property (p_pre13) else $error("tick gap too short for factor 13");

  property p_div1;
    @(posedge clk) disable iff (!rstN)
    run && $past(run) && factor == 11'h001 && $past(factor) == 11'h001 |-> tick;
  endproperty
  a_div1: assert property (p_div1) else $error("factor one must tick every cycle");
endmodule

// *** src/async_serial_tx_baud.sv ***
// serial transmitter, receiver framing check and baud divider behind an AHB-Lite slave
`timescale 1ns/1ps
module async_serial_tx_baud (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // serial line
  input wire logic rxd,
  output logic txd,
  output logic txOwned,
  // cpu interrupt
  input wire logic cpuMask,
  output logic irqReq
);
  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rstMeta_q, rstN;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rstMeta_q <= 1'b0;
      rstN <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstN <= rstMeta_q;
    end
  end

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  logic dpValid_q, dpWrite_q;
  logic [7:0] dpAddr_q;
  logic apTake, apRead, wrEn, statusAcc, statusRd, dataRd, dataWr;
  logic armedTx_q, armedRx_q;
  logic [7:0] ctrl1_q, ctrl2_q, rate_q, rdVal;
  logic holdingEmpty_q, frameDone_q, receiveFull_q, framingFault_q;
  logic [8:0] rxData_q;

  assign apTake = hsel && htrans[1] && hready;
  assign apRead = apTake && !hwrite;
  assign wrEn = dpValid_q && dpWrite_q;
  assign statusAcc = apTake && haddr == sci_pkg::OFF_STATUS;
  assign statusRd = apRead && haddr == sci_pkg::OFF_STATUS;
  assign dataRd = apRead && haddr == sci_pkg::OFF_DATA;
  assign dataWr = wrEn && dpAddr_q == sci_pkg::OFF_DATA;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      dpValid_q <= 1'b0;
      dpWrite_q <= 1'b0;
      dpAddr_q <= 8'h00;
    end
    else
    begin
      dpValid_q <= apTake;
      dpWrite_q <= hwrite;
      dpAddr_q <= haddr;
    end
  end

  always_comb
  begin
    case (haddr)
      sci_pkg::OFF_STATUS: rdVal = {holdingEmpty_q, frameDone_q, receiveFull_q, 3'b000,
        framingFault_q, 1'b0};
      sci_pkg::OFF_DATA: rdVal = rxData_q[7:0];
      sci_pkg::OFF_CTRL1: rdVal = {rxData_q[8], ctrl1_q[6:0]};
      sci_pkg::OFF_CTRL2: rdVal = ctrl2_q;
      sci_pkg::OFF_RATE: rdVal = rate_q;
      default: rdVal = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      hrdata <= 32'h0000_0000;
    else if (apRead)
      hrdata <= {24'h00_0000, rdVal};
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      ctrl1_q <= sci_pkg::CTRL_RST;
      ctrl2_q <= sci_pkg::CTRL_RST;
      rate_q <= sci_pkg::RATE_RST;
    end
    else if (wrEn)
    begin
      if (dpAddr_q == sci_pkg::OFF_CTRL1)
        ctrl1_q <= {1'b0, hwdata[6:0]};
      if (dpAddr_q == sci_pkg::OFF_CTRL2)
        ctrl2_q <= hwdata[7:0];
      if (dpAddr_q == sci_pkg::OFF_RATE)
        rate_q <= hwdata[7:0];
    end
  end

  // first step of the two-step clear sequences
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      armedTx_q <= 1'b0;
      armedRx_q <= 1'b0;
    end
    else
    begin
      if (statusAcc)
        armedTx_q <= 1'b1;
      else if (dataWr)
        armedTx_q <= 1'b0;
      if (statusRd)
        armedRx_q <= 1'b1;
      else if (dataRd)
        armedRx_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // baud dividers
  // ------------------------------------------------------------
  logic senderOn, recvOn, breakReq, len9;
  logic txTick, rxTick, busy_q;
  assign senderOn = ctrl2_q[sci_pkg::C2_SENDON];
  assign recvOn = ctrl2_q[sci_pkg::C2_RECVON];
  assign breakReq = ctrl2_q[sci_pkg::C2_BRK];
  assign len9 = ctrl1_q[sci_pkg::C1_LEN9];

  rate_gen txRate (
    .clk(clk),
    .rstN(rstN),
    .run(senderOn || busy_q),
    .preCode(rate_q[sci_pkg::RT_PRE +: 2]),
    .divCode(rate_q[sci_pkg::RT_SEND +: 3]),
    .tick(txTick)
  );
  rate_gen rxRate (
    .clk(clk),
    .rstN(rstN),
    .run(recvOn),
    .preCode(rate_q[sci_pkg::RT_PRE +: 2]),
    .divCode(rate_q[sci_pkg::RT_RECV +: 3]),
    .tick(rxTick)
  );

  // ------------------------------------------------------------
  // transmitter
  // ------------------------------------------------------------
  logic [8:0] hold_q, newWord;
  logic [10:0] shift_q, dataFrame;
  logic [3:0] bitsLeft_q, phase_q, frameLen;
  logic holdFull_q, idlePend_q, markPend_q, senderPrev_q, senderChg, senderRise;
  logic bitEnd, frameEnd, canStart, selBreak, selMark, selIdle, selData, startAny;
  sci_pkg::kind_t kind_q;

  assign senderChg = senderOn != senderPrev_q;
  assign senderRise = senderOn && !senderPrev_q;
  assign newWord = {len9 && ctrl1_q[sci_pkg::C1_TX9], hwdata[7:0]};
  assign frameLen = len9 ? sci_pkg::LEN_WORD9 : sci_pkg::LEN_WORD8;
  assign bitEnd = busy_q && txTick && phase_q == sci_pkg::PHASE_LAST;
  assign frameEnd = bitEnd && bitsLeft_q == 4'h1;
  assign canStart = senderOn && (!busy_q || frameEnd);
  assign selBreak = canStart && breakReq;
  assign selMark = canStart && !breakReq && markPend_q;
  assign selIdle = canStart && !breakReq && !markPend_q && idlePend_q;
  assign selData = canStart && !breakReq && !markPend_q && !idlePend_q
    && (holdFull_q || dataWr);
  assign startAny = selBreak || selMark || selIdle || selData;

  always_comb
  begin
    logic [8:0] w;
    w = holdFull_q ? hold_q : newWord;
    dataFrame = len9 ? {1'b1, w, 1'b0} : {2'b11, w[7:0], 1'b0};
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      senderPrev_q <= 1'b0;
    else
      senderPrev_q <= senderOn;
  end

  // holding buffer between bus and shifter
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      hold_q <= 9'h000;
      holdFull_q <= 1'b0;
    end
    else if (senderChg)
      holdFull_q <= 1'b0;
    else if (selData && holdFull_q)
    begin
      holdFull_q <= dataWr;
      hold_q <= newWord;
    end
    else if (dataWr && !selData)
    begin
      holdFull_q <= 1'b1;
      hold_q <= newWord;
    end
  end

  // shifter and bit timing
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      shift_q <= 11'h7FF;
      bitsLeft_q <= 4'h0;
      phase_q <= 4'h0;
      busy_q <= 1'b0;
      kind_q <= sci_pkg::K_IDLE;
    end
    else if (startAny)
    begin
      busy_q <= 1'b1;
      phase_q <= 4'h0;
      bitsLeft_q <= selMark ? sci_pkg::LEN_MARK : frameLen;
      if (selBreak)
      begin
        shift_q <= 11'h000;
        kind_q <= sci_pkg::K_BREAK;
      end
      else if (selData)
      begin
        shift_q <= dataFrame;
        kind_q <= sci_pkg::K_DATA;
      end
      else
      begin
        shift_q <= 11'h7FF;
        kind_q <= selMark ? sci_pkg::K_MARK : sci_pkg::K_IDLE;
      end
    end
    else if (frameEnd)
    begin
      busy_q <= 1'b0;
      shift_q <= 11'h7FF;
    end
    else if (busy_q && txTick)
    begin
      phase_q <= phase_q + 4'h1;
      if (bitEnd)
      begin
        shift_q <= {1'b1, shift_q[10:1]};
        bitsLeft_q <= bitsLeft_q - 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      idlePend_q <= 1'b0;
      markPend_q <= 1'b0;
    end
    else
    begin
      if (senderRise)
        idlePend_q <= 1'b1;
      else if (selIdle)
        idlePend_q <= 1'b0;
      if (frameEnd && kind_q == sci_pkg::K_BREAK && !breakReq)
        markPend_q <= 1'b1;
      else if (selMark || !senderOn)
        markPend_q <= 1'b0;
    end
  end

  assign txd = shift_q[0];
  assign txOwned = senderOn || busy_q;

  // ------------------------------------------------------------
  // transmit flags
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      holdingEmpty_q <= 1'b1;
      frameDone_q <= 1'b1;
    end
    else
    begin
      if (selData || senderChg)
        holdingEmpty_q <= 1'b1;
      else if (dataWr && armedTx_q)
        holdingEmpty_q <= 1'b0;
      if (frameEnd && !startAny)
        frameDone_q <= 1'b1;
      else if (dataWr && armedTx_q)
        frameDone_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // receiver
  // ------------------------------------------------------------
  logic rxMeta_q, rxSync_q, rxPrev_q, rxDone;
  logic [3:0] rxCnt_q, rxIdx_q, dataBits;
  logic [8:0] rxSh_q;
  sci_pkg::rxst_t rxSt_q;

  assign dataBits = len9 ? 4'h9 : 4'h8;
  assign rxDone = rxSt_q == sci_pkg::RX_DATA && rxTick
    && rxCnt_q == sci_pkg::PHASE_LAST && rxIdx_q == dataBits;

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      rxMeta_q <= 1'b1;
      rxSync_q <= 1'b1;
      rxPrev_q <= 1'b1;
    end
    else
    begin
      rxMeta_q <= rxd;
      rxSync_q <= rxMeta_q;
      rxPrev_q <= rxSync_q;
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      rxSt_q <= sci_pkg::RX_IDLE;
      rxCnt_q <= 4'h0;
      rxIdx_q <= 4'h0;
      rxSh_q <= 9'h000;
    end
    else if (!recvOn)
      rxSt_q <= sci_pkg::RX_IDLE;
    else
    begin
      case (rxSt_q)
        sci_pkg::RX_IDLE:
          if (rxPrev_q && !rxSync_q)
          begin
            rxSt_q <= sci_pkg::RX_START;
            rxCnt_q <= 4'h0;
          end
        sci_pkg::RX_START:
          if (rxTick)
          begin
            rxCnt_q <= rxCnt_q + 4'h1;
            if (rxCnt_q == sci_pkg::START_MID)
            begin
              rxSt_q <= rxSync_q ? sci_pkg::RX_IDLE : sci_pkg::RX_DATA;
              rxCnt_q <= 4'h0;
              rxIdx_q <= 4'h0;
            end
          end
        sci_pkg::RX_DATA:
          if (rxTick)
          begin
            rxCnt_q <= rxCnt_q + 4'h1;
            if (rxCnt_q == sci_pkg::PHASE_LAST)
            begin
              if (rxIdx_q == dataBits)
                rxSt_q <= sci_pkg::RX_IDLE;
              else
              begin
                rxSh_q <= {rxSync_q, rxSh_q[8:1]};
                rxIdx_q <= rxIdx_q + 4'h1;
              end
            end
          end
        default: rxSt_q <= sci_pkg::RX_IDLE;
      endcase
    end
  end

  // received word and its flags
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      rxData_q <= 9'h000;
      receiveFull_q <= 1'b0;
      framingFault_q <= 1'b0;
    end
    else
    begin
      if (rxDone)
        rxData_q <= len9 ? rxSh_q : {1'b0, rxSh_q[8:1]};
      if (rxDone)
        receiveFull_q <= 1'b1;
      else if (dataRd && armedRx_q)
        receiveFull_q <= 1'b0;
      if (rxDone && !rxSync_q)
        framingFault_q <= 1'b1;
      else if (dataRd && armedRx_q)
        framingFault_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // interrupt request
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      irqReq <= 1'b0;
    else
      irqReq <= !cpuMask && ((holdingEmpty_q && ctrl2_q[sci_pkg::C2_HEIE])
        || (frameDone_q && ctrl2_q[sci_pkg::C2_FDIE])
        || (receiveFull_q && ctrl2_q[sci_pkg::C2_RFIE]));
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_clear_seq;
    @(posedge clk) disable iff (!rstN)
    dataWr && armedTx_q && !selData && !senderChg && !frameEnd
      |=> !holdingEmpty_q && !frameDone_q;
  endproperty
  a_clear_seq: assert property (p_clear_seq) else $error("two-step clear failed");

  property p_idle_load;
    @(posedge clk) disable iff (!rstN)
    dataWr && senderOn && !busy_q && !holdFull_q && !breakReq && !idlePend_q
      && !markPend_q && !senderChg |=> busy_q && holdingEmpty_q && !txd;
  endproperty
  a_idle_load: assert property (p_idle_load) else $error("idle write did not start");

  property p_busy_hold;
    @(posedge clk) disable iff (!rstN)
    dataWr && busy_q && !frameEnd && !senderChg |=> holdFull_q && busy_q;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy write not held");

  property p_break_low;
    @(posedge clk) disable iff (!rstN)
    busy_q && kind_q == sci_pkg::K_BREAK |-> !txd;
  endproperty
  a_break_low: assert property (p_break_low) else $error("break frame not low");

  property p_idle_high;
    @(posedge clk) disable iff (!rstN)
    busy_q && kind_q == sci_pkg::K_IDLE |-> txd;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle frame not high");

  property p_done_flag;
    @(posedge clk) disable iff (!rstN)
    frameEnd && !startAny |=> frameDone_q && !busy_q ##1 (irqReq || $past(cpuMask)
      || !$past(ctrl2_q[sci_pkg::C2_FDIE]));
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("done flag or request missing");

  property p_irq_mask;
    @(posedge clk) disable iff (!rstN)
    cpuMask |=> !irqReq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("request while masked");

  property p_toggle_drop;
    @(posedge clk) disable iff (!rstN)
    senderChg |=> !holdFull_q && holdingEmpty_q;
  endproperty
  a_toggle_drop: assert property (p_toggle_drop) else $error("held word survived");

  property p_fault_full;
    @(posedge clk) disable iff (!rstN)
    $rose(framingFault_q) |-> receiveFull_q && $past(rxDone);
  endproperty
  a_fault_full: assert property (p_fault_full) else $error("fault without full flag");
endmodule

// *** bench/serial_peer.sv ***
// far-end serial transceiver model: captures frames from txd, sends frames on rxd
`timescale 1ns/1ps
module serial_peer (
  // clock
  input wire logic clk,
  // line and format
  input wire logic txd,
  input wire logic len9,
  input wire logic [11:0] bitLen,
  output logic rxd,
  // capture
  output logic [10:0] lastFrame,
  output logic [7:0] frameCount
);
  initial
  begin
    rxd = 1'b1;
    frameCount = 8'h00;
    lastFrame = 11'h000;
    forever
    begin
      @(negedge txd);
      lastFrame = 11'h000;
      repeat (bitLen / 2) @(negedge clk);
      for (int i = 0; i < (len9 ? 11 : 10); i++)
      begin
        lastFrame[i] = txd;
        if (i < (len9 ? 10 : 9))
          repeat (bitLen) @(negedge clk);
      end
      frameCount = frameCount + 8'h01;
    end
  end
  // lsb first, then the line returns to its idle high level
  task automatic send(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      rxd <= bits[i];
      repeat (bitLen) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask
endmodule

// *** bench/async_serial_tx_baud_tb.sv ***
// self-checking bench for the serial transmitter, receiver check and baud divider
`timescale 1ns/1ps
module async_serial_tx_baud_tb;
  logic clk, nrst, hsel, hwrite, rxd, txd, txOwned, cpuMask, irqReq, hreadyout, hresp, len9;
  logic [7:0] haddr, frameCount;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [10:0] lastFrame;
  logic [11:0] bitLen;
  int errors = 0;
  int samples_checked = 0;
  localparam logic [31:0] SEND = 32'h0000_0008;
  localparam logic [31:0] RECV = 32'h0000_0004;
  localparam logic [31:0] BRK = 32'h0000_0001;
  async_serial_tx_baud u_dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxd(rxd), .txd(txd),
    .txOwned(txOwned), .cpuMask(cpuMask), .irqReq(irqReq));
  serial_peer u_peer (.clk(clk), .txd(txd), .len9(len9), .bitLen(bitLen), .rxd(rxd),
    .lastFrame(lastFrame), .frameCount(frameCount));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(n, e, rd);
  endtask
  task automatic put(input logic [31:0] d);
    bus(1'b0, sci_pkg::OFF_STATUS, 32'h0000_0000);
    wr(sci_pkg::OFF_DATA, d);
  endtask
  task automatic waitTx(input logic lvl, output int n);
    n = 0;
    while (txd !== lvl && n < 60000)
    begin
      @(posedge clk);
      n++;
    end
    chk("tx wait", 32'h0000_0000, {31'h0, n >= 60000});
  endtask
  // waits for the capture count, then lets the stop bit run out
  task automatic waitFrames(input logic [7:0] t, input logic [10:0] e);
    int n = 0;
    while (frameCount !== t && n < 60000)
    begin
      @(posedge clk);
      n++;
    end
    chk("frame wait", 32'h0000_0000, {31'h0, n >= 60000});
    chk("peer frame", {21'h0, e}, {21'h0, lastFrame});
    repeat (bitLen) @(posedge clk);
  endtask
  task automatic t_reset;
    rdchk("status", sci_pkg::OFF_STATUS, 32'h0000_00C0);
    rdchk("ctrl2", sci_pkg::OFF_CTRL2, 32'h0000_0000);
    rdchk("rate", sci_pkg::OFF_RATE, 32'h0000_0000);
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
    chk("pin free", 32'h0000_0000, {31'h0, txOwned});
    wr(8'h14, 32'h0000_00FF);
    rdchk("unmapped", 8'h14, 32'h0000_0000);
    $display("test reset done");
  endtask
  task automatic t_frame;
    int n;
    wr(sci_pkg::OFF_CTRL2, SEND);
    put(32'h0000_005A);
    rdchk("held", sci_pkg::OFF_STATUS, 32'h0000_0000);
    chk("pin owned", 32'h0000_0001, {31'h0, txOwned});
    waitTx(1'b0, n);
    chk("idle gap", 32'h0000_0001, {31'h0, n > 130});
    waitFrames(8'h01, {2'b01, 8'h5A, 1'b0});
    rdchk("done", sci_pkg::OFF_STATUS, 32'h0000_00C0);
    $display("test frame done");
  endtask
  task automatic t_b2b;
    logic [7:0] f;
    f = frameCount;
    put(32'h0000_0011);
    wr(sci_pkg::OFF_DATA, 32'h0000_0022);
    rdchk("no access", sci_pkg::OFF_STATUS, 32'h0000_0080);
    wr(sci_pkg::OFF_DATA, 32'h0000_0033);
    rdchk("cleared", sci_pkg::OFF_STATUS, 32'h0000_0000);
    waitFrames(f + 8'h01, {2'b01, 8'h11, 1'b0});
    rdchk("reload", sci_pkg::OFF_STATUS, 32'h0000_0080);
    waitFrames(f + 8'h02, {2'b01, 8'h33, 1'b0});
    rdchk("done", sci_pkg::OFF_STATUS, 32'h0000_00C0);
    wr(sci_pkg::OFF_CTRL1, 32'h0000_0050);
    len9 <= 1'b1;
    put(32'h0000_000F);
    waitFrames(f + 8'h03, {2'b11, 8'h0F, 1'b0});
    wr(sci_pkg::OFF_CTRL1, 32'h0000_0000);
    len9 <= 1'b0;
    $display("test b2b done");
  endtask
  task automatic t_toggle;
    logic [7:0] f;
    int n;
    f = frameCount;
    put(32'h0000_0033);
    put(32'h0000_0044);
    wr(sci_pkg::OFF_CTRL2, 32'h0000_0000);
    wr(sci_pkg::OFF_CTRL2, SEND);
    rdchk("dropped", sci_pkg::OFF_STATUS, 32'h0000_0080);
    waitFrames(f + 8'h01, {2'b01, 8'h33, 1'b0});
    put(32'h0000_0055);
    waitTx(1'b0, n);
    chk("idle after word", 32'h0000_0001, {31'h0, n > 100});
    waitFrames(f + 8'h02, {2'b01, 8'h55, 1'b0});
    $display("test toggle done");
  endtask
  task automatic t_break;
    logic [7:0] f;
    int n;
    wr(sci_pkg::OFF_CTRL2, SEND | BRK);
    waitTx(1'b0, n);
    n = 0;
    repeat (330)
    begin
      @(posedge clk);
      if (txd !== 1'b0)
        n++;
    end
    chk("break low", 32'h0000_0000, n);
    wr(sci_pkg::OFF_CTRL2, SEND);
    waitTx(1'b1, n);
    f = frameCount;
    put(32'h0000_005A);
    waitFrames(f + 8'h01, {2'b01, 8'h5A, 1'b0});
    $display("test break done");
  endtask
  task automatic t_rx;
    wr(sci_pkg::OFF_CTRL2, SEND | RECV);
    u_peer.send({2'b01, 8'h3C, 1'b0}, 10);
    repeat (8) @(posedge clk);
    rdchk("rx full", sci_pkg::OFF_STATUS, 32'h0000_00E0);
    rdchk("rx word", sci_pkg::OFF_DATA, 32'h0000_003C);
    u_peer.send({2'b00, 8'h81, 1'b0}, 10);
    repeat (8) @(posedge clk);
    rdchk("fault", sci_pkg::OFF_STATUS, 32'h0000_00E2);
    rdchk("fault word", sci_pkg::OFF_DATA, 32'h0000_0081);
    rdchk("fault clear", sci_pkg::OFF_STATUS, 32'h0000_00C0);
    u_peer.send(11'h000, 10);
    repeat (8) @(posedge clk);
    rdchk("break rx", sci_pkg::OFF_STATUS, 32'h0000_00E2);
    rdchk("break word", sci_pkg::OFF_DATA, 32'h0000_0000);
    $display("test rx done");
  endtask
  task automatic t_irq;
    wr(sci_pkg::OFF_CTRL2, SEND | 32'h0000_0080);
    repeat (2) @(posedge clk);
    chk("irq empty", 32'h0000_0001, {31'h0, irqReq});
    cpuMask <= 1'b1;
    repeat (2) @(posedge clk);
    chk("irq masked", 32'h0000_0000, {31'h0, irqReq});
    cpuMask <= 1'b0;
    wr(sci_pkg::OFF_CTRL2, SEND | 32'h0000_0040);
    repeat (2) @(posedge clk);
    chk("irq done", 32'h0000_0001, {31'h0, irqReq});
    wr(sci_pkg::OFF_CTRL2, SEND);
    repeat (2) @(posedge clk);
    chk("irq off", 32'h0000_0000, {31'h0, irqReq});
    $display("test irq done");
  endtask
  task automatic t_rate;
    logic [7:0] code [4] = '{8'h4F, 8'hC0, 8'h90, 8'h38};
    int bt [4] = '{96, 208, 256, 2048};
    int n;
    foreach (code[i])
    begin
      wr(sci_pkg::OFF_CTRL2, 32'h0000_0000);
      wr(sci_pkg::OFF_RATE, {24'h0, code[i]});
      bitLen <= 12'(bt[i]);
      wr(sci_pkg::OFF_CTRL2, SEND);
      put(32'h0000_0001);
      waitTx(1'b0, n);
      waitTx(1'b1, n);
      chk("bit time", 32'h0000_0001,
        {31'h0, n >= bt[i] * 15 / 16 - 1 && n <= bt[i] * 17 / 16 + 1});
      waitFrames(frameCount + 8'h01, {2'b01, 8'h01, 1'b0});
    end
    wr(sci_pkg::OFF_CTRL2, 32'h0000_0000);
    $display("test rate done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #900_000;
    errors++;
    finish_test;
  end
  initial
  begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    cpuMask = 1'b0;
    len9 = 1'b0;
    bitLen = 12'h010;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_frame;
    t_b2b;
    t_toggle;
    t_break;
    t_rx;
    t_irq;
    t_rate;
    finish_test;
  end
endmodule
